// >>> rtl/tmcc_top.v
// Four timer modules sharing a prescaler, each with its own counter, compare, pin and byte access.
//
// What this block does
// R1: Four timers, standard or periodic type.
// R2: Free counter compares; match clears, changes pin.
// R3: Interrupt sources from compare A and P.
// R4: Three-bit field selects counter clock source.
// R5: External clock pin edge rising or falling.
// R6: External clock pin triggers single pulse.
// R7: Capture on rising, falling or both edges.
// R8: Periodic timers may capture from clock pin.
// R9: Inverted output always mirrors main output.
// R10: Compare match drives pin high, low, toggle.
// R11: One edge PWM and single pulse each.
// R12: Software selects pin sharing before use.
// R13: Timers 0,1 have inverted outputs; 2,3 not.
// R14: High byte direct, low byte through buffer.
// R15: Low write buffers; compare high write commits both, counter high write is ignored.
// R16: High read latches low into buffer.
// R17: Software writes low first, reads high first.
// R18: Clock codes: sys/4, sys, h/16, h/64, sub, pin.
// R19: Capture codes: rise, fall, both, disabled.
// R20: Pins synchronised before edge detection.
`include "tmcc_defs.vh"

module tmcc_top (
	input  wire       mclk,
	input  wire       rst,
	input  wire [5:0] addr,
	input  wire [7:0] wdata,
	input  wire       wr_en,
	input  wire       rd_en,
	output reg  [7:0] rdata,
	input  wire       sub_clk_pin,
	input  wire       std_ext_clk_pin,
	input  wire [2:0] per_ext_clk_pin,
	input  wire       std_capture_pin,
	input  wire [2:0] per_capture_pin,
	output wire       std_out_pin,
	output wire       std_out_inv_pin,
	output wire [2:0] per_out_pin,
	output wire       per0_out_inv_pin,
	output wire [3:0] match_a_pulse,
	output wire [3:0] match_p_pulse
);

	// ------------------------------------------------------------------
	// Shared prescaler and sub clock edge
	// ------------------------------------------------------------------
	reg  [`TMCC_PRE_W-1:0] pre_reg;
	wire                   tick_4;
	wire                   tick_16;
	wire                   tick_64;
	wire                   sub_rise;
	wire [3:0]             ext_pins;
	wire [3:0]             cap_pins;
	wire [3:0]             ext_rise;
	wire [3:0]             ext_fall;
	wire [3:0]             cap_rise;
	wire [3:0]             cap_fall;
	wire [31:0]            rd_all;
	wire [3:0]             pin_lvl;
	wire [3:0]             pin_inv;

	// Free-running divider; each rate is a one-cycle enable.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pre_reg <= {`TMCC_PRE_W{1'b0}};
		end else begin
			pre_reg <= pre_reg + 1'b1;
		end
	end

	assign tick_4  = &pre_reg[1:0];
	assign tick_16 = &pre_reg[3:0];
	assign tick_64 = &pre_reg;

	tmcc_edge u_sub (
		.mclk (mclk),
		.rst  (rst),
		.pin  (sub_clk_pin),
		.rise (sub_rise),
		.fall ()
	);

	assign ext_pins = {per_ext_clk_pin, std_ext_clk_pin};
	assign cap_pins = {per_capture_pin, std_capture_pin};

	// ------------------------------------------------------------------
	// Timer instances (0 standard, 1..3 periodic)
	// ------------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < `TMCC_NUM_TM; i = i + 1) begin : g_tm // R1
			reg  [7:0]  ctrl0_reg;
			reg  [7:0]  ctrl1_reg;
			reg  [15:0] cnt_reg;
			reg  [15:0] cmpa_reg;
			reg  [15:0] cmpp_reg;
			reg  [7:0]  buf_reg;
			reg         on_d_reg;
			reg         out_reg;
			reg         lvl_reg;
			reg         sp_run_reg;
			reg         match_a_reg;
			reg         match_p_reg;
			reg         tick;
			reg         cap_evt;
			reg         pwm_act;
			reg  [7:0]  rd_word;
			wire [1:0]  mode;
			wire [1:0]  pfn;
			wire [2:0]  cksel;
			wire        on;
			wire        on_rise;
			wire        hit;
			wire        wr_hit;
			wire        rd_hit;
			wire        sp_mode;
			wire        sp_trig;
			wire        run;
			wire        ena;
			wire        hit_a;
			wire        hit_p;
			wire        clr_on_a;
			wire        src_rise;
			wire        src_fall;
			wire [15:0] duty;

			tmcc_edge u_ext (
				.mclk (mclk),
				.rst  (rst),
				.pin  (ext_pins[i]),
				.rise (ext_rise[i]),
				.fall (ext_fall[i])
			);

			tmcc_edge u_cap (
				.mclk (mclk),
				.rst  (rst),
				.pin  (cap_pins[i]),
				.rise (cap_rise[i]),
				.fall (cap_fall[i])
			);

			// Field decode and bus selection.
			assign mode  = ctrl1_reg[`TMCC_C1_MODE_HI:`TMCC_C1_MODE_LO];
			assign pfn   = ctrl1_reg[`TMCC_C1_PFN_HI:`TMCC_C1_PFN_LO];
			assign cksel = ctrl0_reg[`TMCC_C0_CKSEL_HI:`TMCC_C0_CKSEL_LO];
			assign on      = ctrl0_reg[`TMCC_C0_ON];
			assign on_rise = on & ~on_d_reg;
			assign hit     = ({30'h0, addr[5:4]} == i);
			assign wr_hit  = wr_en & hit;
			assign rd_hit  = rd_en & hit;

			// Clock source selection.
			always @* begin
				case (cksel) // R4
				`TMCC_CK_SYS4:     tick = tick_4; // R18
				`TMCC_CK_SYS:      tick = 1'b1; // R18
				`TMCC_CK_H16:      tick = tick_16; // R18
				`TMCC_CK_H64:      tick = tick_64; // R18
				`TMCC_CK_SUB0,
				`TMCC_CK_SUB1:     tick = sub_rise; // R18
				`TMCC_CK_EXT_RISE: tick = ext_rise[i]; // R5
				`TMCC_CK_EXT_FALL: tick = ext_fall[i]; // R5
				default:           tick = 1'b0;
				endcase
			end

			// Single pulse waits for its trigger before counting.
			assign sp_mode = (mode == `TMCC_MODE_PWM) & (pfn == `TMCC_PF_3);
			assign sp_trig = sp_mode & on & ext_rise[i] & ~sp_run_reg; // R6
			assign run = on & ~ctrl0_reg[`TMCC_C0_PAUSE] &
				(~sp_mode | sp_run_reg);
			assign ena   = run & tick;
			assign hit_a = ena & (cnt_reg == cmpa_reg); // R2
			assign hit_p = ena & (cnt_reg == cmpp_reg); // R2
			// PWM: the period comparator clears, the other sets duty.
			assign clr_on_a = (mode == `TMCC_MODE_PWM) ?
				ctrl1_reg[`TMCC_C1_DPX] : ctrl1_reg[`TMCC_C1_CCLR];
			assign duty = ctrl1_reg[`TMCC_C1_DPX] ? cmpp_reg : cmpa_reg; // R11

			// Capture source: periodic timers may use the clock pin.
			assign src_rise = (i != 0 && ctrl1_reg[`TMCC_C1_DPX]) ?
				ext_rise[i] : cap_rise[i]; // R8
			assign src_fall = (i != 0 && ctrl1_reg[`TMCC_C1_DPX]) ?
				ext_fall[i] : cap_fall[i]; // R8

			// Capture edge selection.
			always @* begin
				case (pfn) // R7
				`TMCC_PF_0: cap_evt = src_rise; // R19
				`TMCC_PF_1: cap_evt = src_fall; // R19
				`TMCC_PF_2: cap_evt = src_rise | src_fall; // R19
				default:    cap_evt = 1'b0; // R19
				endcase
				if (mode != `TMCC_MODE_CAP || !on) begin
					cap_evt = 1'b0;
				end
			end

			// PWM active phase per pin function.
			always @* begin
				case (pfn) // R11
				`TMCC_PF_0: pwm_act = 1'b0;
				`TMCC_PF_1: pwm_act = 1'b1;
				`TMCC_PF_2: pwm_act = on & (cnt_reg < duty);
				default:    pwm_act = sp_run_reg;
				endcase
			end

			// Read mux for this timer.
			always @* begin
				case (addr[3:0])
				`TMCC_OFS_CTRL0:   rd_word = ctrl0_reg;
				`TMCC_OFS_CTRL1:   rd_word = ctrl1_reg;
				`TMCC_OFS_CNT_LO:  rd_word = buf_reg; // R16
				`TMCC_OFS_CNT_HI:  rd_word = cnt_reg[15:8]; // R14
				`TMCC_OFS_CMPA_LO: rd_word = buf_reg; // R16
				`TMCC_OFS_CMPA_HI: rd_word = cmpa_reg[15:8]; // R14
				`TMCC_OFS_CMPP_LO: rd_word = buf_reg; // R16
				`TMCC_OFS_CMPP_HI: rd_word = cmpp_reg[15:8]; // R14
				default:           rd_word = 8'h00;
				endcase
			end
			assign rd_all[i*8 +: 8] = rd_word;

			// Registers, byte buffer, counter and output state.
			always @(posedge mclk or posedge rst) begin
				if (rst) begin
					ctrl0_reg   <= `TMCC_RST_BYTE;
					ctrl1_reg   <= `TMCC_RST_BYTE;
					cnt_reg     <= `TMCC_RST_WORD;
					cmpa_reg    <= `TMCC_RST_WORD;
					cmpp_reg    <= `TMCC_RST_WORD;
					buf_reg     <= `TMCC_RST_BYTE;
					on_d_reg    <= 1'b0;
					out_reg     <= 1'b0;
					lvl_reg     <= 1'b0;
					sp_run_reg  <= 1'b0;
					match_a_reg <= 1'b0;
					match_p_reg <= 1'b0;
				end else begin
					on_d_reg    <= on;
					match_a_reg <= hit_a; // R3
					match_p_reg <= hit_p; // R3
					// Bus writes: low bytes only fill the buffer.
					if (wr_hit) begin
						case (addr[3:0])
						`TMCC_OFS_CTRL0:   ctrl0_reg <= wdata;
						`TMCC_OFS_CTRL1:   ctrl1_reg <= wdata;
						`TMCC_OFS_CNT_LO,
						`TMCC_OFS_CMPA_LO,
						`TMCC_OFS_CMPP_LO: buf_reg <= wdata; // R15
						`TMCC_OFS_CMPA_HI: cmpa_reg <= {wdata, buf_reg}; // R15
						`TMCC_OFS_CMPP_HI: cmpp_reg <= {wdata, buf_reg}; // R15
						default:           buf_reg <= buf_reg;
						endcase
					end
					// High-byte reads latch the low byte.
					if (rd_hit) begin
						case (addr[3:0])
						`TMCC_OFS_CNT_HI:  buf_reg <= cnt_reg[7:0]; // R16
						`TMCC_OFS_CMPA_HI: buf_reg <= cmpa_reg[7:0]; // R16
						`TMCC_OFS_CMPP_HI: buf_reg <= cmpp_reg[7:0]; // R16
						default:           buf_reg <= buf_reg;
						endcase
					end
					// A capture overrides a bus write in the same cycle.
					if (cap_evt) begin
						cmpa_reg <= cnt_reg; // R7
					end
					// Counter: restart on switch-on or trigger.
					if (on_rise || sp_trig) begin
						cnt_reg <= `TMCC_RST_WORD;
					end else if (ena) begin
						if (clr_on_a ? hit_a : hit_p) begin
							cnt_reg <= `TMCC_RST_WORD; // R2
						end else begin
							cnt_reg <= cnt_reg + 16'h0001; // R2
						end
					end
					// Single pulse runs from trigger to compare A.
					if (sp_trig) begin
						sp_run_reg <= 1'b1; // R6
					end else if (hit_a || !on || !sp_mode) begin
						sp_run_reg <= 1'b0;
					end
					// Output state per mode.
					if (mode == `TMCC_MODE_CMP) begin
						if (on_rise) begin
							out_reg <= ctrl1_reg[`TMCC_C1_OC];
						end else if (hit_a) begin
							case (pfn) // R10
							`TMCC_PF_1: out_reg <= 1'b0;
							`TMCC_PF_2: out_reg <= 1'b1;
							`TMCC_PF_3: out_reg <= ~out_reg;
							default:    out_reg <= out_reg;
							endcase
						end
					end else if (mode == `TMCC_MODE_PWM) begin
						out_reg <= pwm_act ? ctrl1_reg[`TMCC_C1_OC] :
							~ctrl1_reg[`TMCC_C1_OC]; // R11
					end
					lvl_reg <= out_reg ^ ctrl1_reg[`TMCC_C1_POL];
				end
			end

			assign pin_lvl[i]       = lvl_reg;
			assign match_a_pulse[i] = match_a_reg;
			assign match_p_pulse[i] = match_p_reg;
		end
	endgenerate

	// ------------------------------------------------------------------
	// Output pins and inverted companions
	// ------------------------------------------------------------------
	reg [3:0] pin_reg;
	reg [1:0] inv_reg;

	// Main and inverted pins update together from one level.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pin_reg <= 4'h0;
			inv_reg <= 2'h3;
		end else begin
			pin_reg <= pin_lvl;
			inv_reg <= ~pin_lvl[1:0]; // R9 R13
		end
	end

	assign pin_inv          = {2'h0, inv_reg};
	assign std_out_pin      = pin_reg[0];
	assign per_out_pin      = pin_reg[3:1];
	assign std_out_inv_pin  = pin_inv[0]; // R13
	assign per0_out_inv_pin = pin_inv[1]; // R13

	// ------------------------------------------------------------------
	// Register read port
	// ------------------------------------------------------------------
	// Data stand in the cycle after the strobe only.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata <= 8'h00;
		end else if (rd_en) begin
			rdata <= rd_all[addr[5:4]*8 +: 8];
		end else begin
			rdata <= 8'h00;
		end
	end

endmodule // tmcc_top

// >>> rtl/tmcc_defs.vh
// Register offsets, field positions, codes and reset values of the timers.
`ifndef TMCC_DEFS_VH
`define TMCC_DEFS_VH

// ----------------------------------------------------------------------
// Register offsets inside one timer (address bits 3:0)
// ----------------------------------------------------------------------
`define TMCC_OFS_CTRL0    4'h0
`define TMCC_OFS_CTRL1    4'h1
`define TMCC_OFS_CNT_LO   4'h2
`define TMCC_OFS_CNT_HI   4'h3
`define TMCC_OFS_CMPA_LO  4'h4
`define TMCC_OFS_CMPA_HI  4'h5
`define TMCC_OFS_CMPP_LO  4'h6
`define TMCC_OFS_CMPP_HI  4'h7

// ----------------------------------------------------------------------
// Field positions of control register 0
// ----------------------------------------------------------------------
`define TMCC_C0_PAUSE     7
`define TMCC_C0_CKSEL_HI  6
`define TMCC_C0_CKSEL_LO  4
`define TMCC_C0_ON        3

// ----------------------------------------------------------------------
// Field positions of control register 1
// ----------------------------------------------------------------------
`define TMCC_C1_MODE_HI   7
`define TMCC_C1_MODE_LO   6
`define TMCC_C1_PFN_HI    5
`define TMCC_C1_PFN_LO    4
`define TMCC_C1_OC        3
`define TMCC_C1_POL       2
`define TMCC_C1_DPX       1
`define TMCC_C1_CCLR      0

// ----------------------------------------------------------------------
// Operating modes
// ----------------------------------------------------------------------
`define TMCC_MODE_CMP     2'h0
`define TMCC_MODE_CAP     2'h1
`define TMCC_MODE_PWM     2'h2
`define TMCC_MODE_TMR     2'h3

// ----------------------------------------------------------------------
// Clock select codes
// ----------------------------------------------------------------------
`define TMCC_CK_SYS4      3'h0
`define TMCC_CK_SYS       3'h1
`define TMCC_CK_H16       3'h2
`define TMCC_CK_H64       3'h3
`define TMCC_CK_SUB0      3'h4
`define TMCC_CK_SUB1      3'h5
`define TMCC_CK_EXT_RISE  3'h6
`define TMCC_CK_EXT_FALL  3'h7

// ----------------------------------------------------------------------
// Pin function codes
// ----------------------------------------------------------------------
`define TMCC_PF_0         2'h0
`define TMCC_PF_1         2'h1
`define TMCC_PF_2         2'h2
`define TMCC_PF_3         2'h3

// ----------------------------------------------------------------------
// Reset values and prescaler
// ----------------------------------------------------------------------
`define TMCC_RST_BYTE     8'h00
`define TMCC_RST_WORD     16'h0000
`define TMCC_PRE_W        6
`define TMCC_NUM_TM       4

`endif

// >>> rtl/tmcc_edge.v
// Two-stage pin synchroniser with rising and falling edge detection.
module tmcc_edge (
	input  wire mclk,
	input  wire rst,
	input  wire pin,
	output wire rise,
	output wire fall
);

	reg [2:0] sync_reg;

	// ------------------------------------------------------------------
	// Synchroniser and history
	// ------------------------------------------------------------------
	// Only the second and third stages feed the edge detectors.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			sync_reg <= 3'h0;
		end else begin
			sync_reg <= {sync_reg[1:0], pin}; // R20
		end
	end

	// One event per qualifying edge.
	assign rise = sync_reg[1] & ~sync_reg[2]; // R20
	assign fall = ~sync_reg[1] & sync_reg[2]; // R20

endmodule // tmcc_edge

// >>> verif/tmcc_monitor.sv
// Concurrent checks on the bus and output pins of the timer block.
module tmcc_monitor (
	input wire       mclk,
	input wire       rst,
	input wire [5:0] addr,
	input wire [7:0] wdata,
	input wire       wr_en,
	input wire       rd_en,
	input wire [7:0] rdata,
	input wire       std_out_pin,
	input wire       std_out_inv_pin,
	input wire       per0_out_inv_pin,
	input wire [2:0] per_out_pin,
	input wire [3:0] match_a_pulse
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [7:0] c0_s [0:3];
	reg [7:0] c1_s [0:3];
	reg [7:0] exp_q;
	integer   i;

	// Shadow control bytes; exp_q holds what a read here returns.
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			for (i = 0; i < 4; i = i + 1) begin
				c0_s[i] <= 8'h00;
				c1_s[i] <= 8'h00;
			end
			exp_q <= 8'h00;
		end else begin
			if (wr_en && addr[3:0] == 4'h0) c0_s[addr[5:4]] <= wdata;
			if (wr_en && addr[3:0] == 4'h1) c1_s[addr[5:4]] <= wdata;
			exp_q <= addr[0] ? c1_s[addr[5:4]] : c0_s[addr[5:4]];
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	std_inv_a: assert property (std_out_inv_pin != std_out_pin)
		else $error("std inverted pin equals main pin");
	per_inv_a: assert property (per0_out_inv_pin != per_out_pin[0])
		else $error("per0 inverted pin equals main pin");
	rdata_idle_a: assert property (!rd_en |=> rdata == 8'h00)
		else $error("read data outside its read cycle");
	unmap_rd_a: assert property (rd_en && addr[3] |=> rdata == 8'h00)
		else $error("unmapped offset read not zero");
	ctrl0_rb_a: assert property (rd_en && addr[3:0] == 4'h0 |=> rdata == exp_q)
		else $error("control 0 read back differs");
	ctrl1_rb_a: assert property (rd_en && addr[3:0] == 4'h1 |=> rdata == exp_q)
		else $error("control 1 read back differs");
	rst_out_a: assert property ($fell(rst) |-> !std_out_pin && match_a_pulse == 4'h0)
		else $error("outputs not at reset level");
	rst_hold_a: assert property ($fell(rst) |=> (std_out_inv_pin && per0_out_inv_pin) [*2])
		else $error("inverted pins left reset level early");
endmodule // tmcc_monitor

bind tmcc_top tmcc_monitor u_tmcc_monitor (
	.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
	.rd_en(rd_en), .rdata(rdata), .std_out_pin(std_out_pin),
	.std_out_inv_pin(std_out_inv_pin), .per0_out_inv_pin(per0_out_inv_pin),
	.per_out_pin(per_out_pin), .match_a_pulse(match_a_pulse)
);

// >>> verif/tmcc_pin.sv
// Pin-side model: external clock, capture and sub clock sources.
module tmcc_pin (
	input  wire       mclk,
	output reg        sub_clk_pin,
	output reg  [3:0] ext_clk,
	output reg  [3:0] cap
);
	timeunit 1ns;
	timeprecision 1ps;
	reg [2:0] sub_cnt_reg;

	// Pins idle low until a test moves them.
	initial begin
		sub_clk_pin = 1'b0;
		ext_clk = 4'h0;
		cap = 4'h0;
		sub_cnt_reg = 3'h0;
	end

	// The sub oscillator runs free, toggling every eight clocks.
	always @(posedge mclk) begin
		sub_cnt_reg <= sub_cnt_reg + 3'h1;
		if (sub_cnt_reg == 3'h7) sub_clk_pin <= ~sub_clk_pin;
	end

	// Levels are held four clocks so the synchroniser sees each edge.
	task ext_set(input int t, input logic v);
		@(posedge mclk);
		ext_clk[t] <= v;
		repeat (4) @(posedge mclk);
	endtask

	// Capture pin level change, held the same way.
	task cap_set(input int t, input logic v);
		@(posedge mclk);
		cap[t] <= v;
		repeat (4) @(posedge mclk);
	endtask

	// Whole pulses on an external clock pin.
	task ext_pulses(input int t, input int n);
		repeat (n) begin
			ext_set(t, 1'b1);
			ext_set(t, 1'b0);
		end
	endtask
endmodule // tmcc_pin

// >>> verif/timer_module_common_core_tb_top.sv
// Self-checking bench for the four-timer block.
module timer_module_common_core_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        rst;
	logic [5:0]  addr;
	logic [7:0]  wdata;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  d;
	logic [1:0]  pf;
	wire  [7:0]  rdata;
	wire         sub_clk_pin;
	wire  [3:0]  ext_clk;
	wire  [3:0]  cap;
	wire         std_out_pin;
	wire         std_out_inv_pin;
	wire  [2:0]  per_out_pin;
	wire         per0_out_inv_pin;
	wire  [3:0]  match_a_pulse;
	wire  [3:0]  match_p_pulse;
	int          fails;
	int          cmp_count;
	int          ma_n;
	int          mp_n;
	int          m0;
	int          p0;

	tmcc_top u_tmcc_top (
		.mclk(mclk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.sub_clk_pin(sub_clk_pin), .std_ext_clk_pin(ext_clk[0]),
		.per_ext_clk_pin(ext_clk[3:1]), .std_capture_pin(cap[0]),
		.per_capture_pin(cap[3:1]), .std_out_pin(std_out_pin),
		.std_out_inv_pin(std_out_inv_pin), .per_out_pin(per_out_pin),
		.per0_out_inv_pin(per0_out_inv_pin),
		.match_a_pulse(match_a_pulse), .match_p_pulse(match_p_pulse)
	);
	tmcc_pin u_tmcc_pin (.mclk(mclk), .sub_clk_pin(sub_clk_pin),
		.ext_clk(ext_clk), .cap(cap));

	// Clock of 40 ns period.
	always #20 mclk = ~mclk;

	// Count compare match pulses of the standard timer.
	always @(posedge mclk) begin
		if (match_a_pulse[0] === 1'b1) ma_n <= ma_n + 1;
		if (match_p_pulse[0] === 1'b1) mp_n <= mp_n + 1;
	end

	// Compare, count and report a mismatch.
	task chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	// Bus write; the strobe stays up until the next access or nop.
	task wr(input logic [5:0] a, input logic [7:0] v);
		@(posedge mclk);
		wr_en <= 1'b1;
		rd_en <= 1'b0;
		addr <= a;
		wdata <= v;
	endtask

	// Release the strobes and let a few clocks pass.
	task nop;
		@(posedge mclk);
		wr_en <= 1'b0;
		rd_en <= 1'b0;
		repeat (3) @(posedge mclk);
	endtask

	// Bus read; data is taken in the cycle after the strobe.
	task rd(input logic [5:0] a, output logic [7:0] v);
		@(posedge mclk);
		rd_en <= 1'b1;
		wr_en <= 1'b0;
		addr <= a;
		@(posedge mclk);
		rd_en <= 1'b0;
		#1 v = rdata;
	endtask

	task rchk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] v;
		rd(a, v);
		chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, v});
	endtask

	// A 16-bit pair is read high byte first.
	task r16(input logic [5:0] a, input logic [15:0] e);
		rchk(a + 6'h01, e[15:8]);
		rchk(a, e[7:0]);
	endtask

	task wrap_up;
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// A hang is cut short and counted as a mismatch.
	initial begin
		repeat (60000) @(posedge mclk);
		fails++;
		wrap_up;
	end

	// Main sequence.
	initial begin
		mclk = 1'b0;
		rst = 1'b1;
		addr = 6'h00;
		wdata = 8'h00;
		wr_en = 1'b0;
		rd_en = 1'b0;
		fails = 0;
		cmp_count = 0;
		ma_n = 0;
		mp_n = 0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		#1;
		chk("inv pin", 16'h1, 16'(per0_out_inv_pin));
		rchk(6'h00, 8'h00);
		$display("test reset done");
		wr(6'h16, 8'h5a);
		wr(6'h17, 8'ha5);
		rchk(6'h17, 8'ha5);
		rchk(6'h16, 8'h5a);
		wr(6'h15, 8'h3c);
		wr(6'h13, 8'hff);
		wr(6'h1c, 8'hff);
		r16(6'h14, 16'h3c5a);
		r16(6'h12, 16'h0000);
		rchk(6'h1c, 8'h00);
		$display("test byte access done");
		for (int c = 6; c < 8; c++) begin
			wr(6'h10, 8'h00);
			wr(6'h11, 8'hc0);
			wr(6'h10, {1'b0, 3'(c), 4'h8});
			nop;
			u_tmcc_pin.ext_set(1, 1'b1);
			r16(6'h12, 16'(c == 6));
			u_tmcc_pin.ext_set(1, 1'b0);
			r16(6'h12, 16'h0001);
			u_tmcc_pin.ext_pulses(1, 2);
			r16(6'h12, 16'h0003);
		end
		$display("test external clock done");
		for (int k = 0; k < 4; k++) begin
			pf = 2'(k);
			d = {2'b00, pf, pf == 2'h1, 3'b001};
			wr(6'h00, 8'h00);
			wr(6'h04, 8'h03);
			wr(6'h05, 8'h00);
			wr(6'h01, d);
			wr(6'h00, 8'h68);
			nop;
			rchk(6'h01, d);
			chk("out", 16'(d[3]), 16'(std_out_pin));
			m0 = ma_n;
			p0 = mp_n;
			u_tmcc_pin.ext_pulses(0, 4);
			#1;
			chk("out", 16'(pf[1]), 16'(std_out_pin));
			chk("inv", 16'(!pf[1]), 16'(std_out_inv_pin));
			chk("match a", 16'h1, 16'(ma_n - m0));
			chk("match p", 16'h1, 16'(mp_n - p0));
		end
		$display("test compare done");
		for (int k = 0; k < 4; k++) begin
			pf = 2'(k);
			wr(6'h20, 8'h00);
			wr(6'h21, {2'b01, pf, 4'h0});
			wr(6'h26, 8'hff);
			wr(6'h27, 8'h00);
			wr(6'h24, 8'h00);
			wr(6'h25, 8'h00);
			wr(6'h20, 8'h68);
			nop;
			u_tmcc_pin.ext_pulses(2, 2);
			u_tmcc_pin.cap_set(2, 1'b1);
			r16(6'h24, pf[0] ? 16'h0000 : 16'h0002);
			u_tmcc_pin.ext_pulses(2, 1);
			u_tmcc_pin.cap_set(2, 1'b0);
			d = pf == 2'h3 ? 8'h00 : (pf == 2'h0 ? 8'h02 : 8'h03);
			r16(6'h24, {8'h00, d});
		end
		// Clock pin as capture source: the capture pin must be ignored.
		wr(6'h20, 8'h00);
		wr(6'h24, 8'hff);
		wr(6'h25, 8'hff);
		wr(6'h21, 8'h42);
		wr(6'h20, 8'he8);
		nop;
		u_tmcc_pin.cap_set(2, 1'b1);
		r16(6'h24, 16'hffff);
		u_tmcc_pin.ext_pulses(2, 1);
		u_tmcc_pin.cap_set(2, 1'b0);
		r16(6'h24, 16'h0000);
		$display("test capture done");
		// A period far away keeps the counter of timer 3 from clearing.
		wr(6'h36, 8'hff);
		wr(6'h37, 8'hff);
		for (int c = 0; c < 8; c++) begin
			wr(6'h30, 8'h00);
			wr(6'h31, 8'hc0);
			wr(6'h30, {1'b0, 3'(c), 4'h8});
			nop;
			repeat (200) @(posedge mclk);
			rd(6'h33, d);
			rd(6'h32, d);
			chk("ticking", 16'(c < 6), 16'(d != 8'h00));
		end
		$display("test clock codes done");
		for (int k = 0; k < 4; k++) begin
			wr(6'h30, 8'h00);
			wr(6'h31, {3'b100, k[0], 1'b1, k[1], 2'b00});
			wr(6'h30, 8'h68);
			nop;
			u_tmcc_pin.ext_pulses(3, 1);
			#1;
			chk("pwm pin", 16'(k[0] ^ k[1]), 16'(per_out_pin[2]));
		end
		$display("test pwm levels done");
		// Duty output: active while the count is below compare A.
		wr(6'h30, 8'h00);
		wr(6'h34, 8'h02);
		wr(6'h35, 8'h00);
		wr(6'h31, 8'ha8);
		wr(6'h30, 8'h68);
		nop;
		#1;
		chk("duty pin", 16'h1, 16'(per_out_pin[2]));
		u_tmcc_pin.ext_pulses(3, 2);
		#1;
		chk("duty pin", 16'h0, 16'(per_out_pin[2]));
		// Single pulse: the clock pin starts it, compare A ends it.
		wr(6'h30, 8'h00);
		wr(6'h34, 8'h10);
		wr(6'h35, 8'h00);
		wr(6'h31, 8'hb8);
		wr(6'h30, 8'h18);
		nop;
		#1;
		chk("pulse pin", 16'h0, 16'(per_out_pin[2]));
		u_tmcc_pin.ext_pulses(3, 1);
		#1;
		chk("pulse pin", 16'h1, 16'(per_out_pin[2]));
		repeat (20) @(posedge mclk);
		#1;
		chk("pulse pin", 16'h0, 16'(per_out_pin[2]));
		$display("test duty and pulse done");
		wrap_up;
	end
endmodule // timer_module_common_core_tb_top
